// ---- hdl/ccm_map.svh ----
`ifndef CCM_MAP_SVH
`define CCM_MAP_SVH

// Register offsets on the plain register port
`define CCM_OFS_MODE     4'h0
`define CCM_OFS_CMP      4'h1
`define CCM_OFS_STATUS   4'h2
`define CCM_OFS_MASK     4'h3
`define CCM_OFS_COUNT    4'h4

// Field positions in the mode register
`define CCM_BIT_IRQ_EN   0
`define CCM_BIT_PWM_EN   1
`define CCM_BIT_TOG_EN   2
`define CCM_BIT_MAT_EN   3
`define CCM_BIT_WIDE     7

// Field positions in the status and mask registers
`define CCM_BIT_ST_MATCH  0
`define CCM_BIT_ST_PERIOD 1

// Reset values
`define CCM_RST_MODE     16'h0000
`define CCM_RST_CMP      16'h0000
`define CCM_RST_STATUS   16'h0000
`define CCM_RST_MASK     16'h0003
`define CCM_RST_RDATA    16'h0000

`endif

// ---- hdl/ccm_pkg.sv ----
`default_nettype none

package ccm_pkg;

  // Register and counter word
  typedef logic [15:0] ccm_word_t;

  // Output pin operating modes
  typedef enum logic [2:0] {
    ccm_m_off,
    ccm_m_toggle,
    ccm_m_pwm8,
    ccm_m_pwm16,
    ccm_m_freq
  } ccm_mode_e;

endpackage : ccm_pkg

`default_nettype wire

// ---- hdl/ccm_pin_gen.sv ----
`timescale 1ns/1ns
`default_nettype none

// Drives the module output pin in the selected mode
module ccm_pin_gen #(
  parameter int LOW_W = 8                      // Width of the narrow PWM and frequency compare
) (
  input  wire logic              i_core_clk,
  input  wire logic              i_resetn,
  input  wire ccm_pkg::ccm_mode_e i_mode,      // Decoded pin mode
  input  wire ccm_pkg::ccm_word_t i_counter,   // Shared counter value
  input  wire ccm_pkg::ccm_word_t i_compare,   // Module compare register
  input  wire logic              i_match_edge, // First cycle of a full match
  output logic                   o_pin_level   // Registered pin level
);

  logic             pin;        // Current pin level
  logic             next_pin;
  logic [LOW_W-1:0] target;     // Next low-byte toggle point in frequency mode
  logic [LOW_W-1:0] next_target;
  logic             lo_hit_q;   // Low-byte hit seen last cycle
  logic             lo_hit;

  // Low byte of the counter meets the frequency target
  assign lo_hit = (i_counter[LOW_W-1:0] == target);

  // Next pin level and frequency target
  always_comb begin
    next_pin    = pin;
    next_target = i_compare[LOW_W-1:0];
    case (i_mode)
      ccm_pkg::ccm_m_off: begin
        // Pin keeps its last level
        next_pin = pin;
      end
      ccm_pkg::ccm_m_toggle: begin
        if (i_match_edge) begin
          next_pin = ~pin;
        end
      end
      ccm_pkg::ccm_m_pwm8: begin
        // High while the low byte is at or past the compare low byte
        next_pin = (i_counter[LOW_W-1:0] >= i_compare[LOW_W-1:0]);
      end
      ccm_pkg::ccm_m_pwm16: begin
        next_pin = (i_counter >= i_compare);
      end
      ccm_pkg::ccm_m_freq: begin
        // Half period is the compare high byte, in counter steps
        next_target = target;
        if (lo_hit && !lo_hit_q) begin
          next_pin    = ~pin;
          next_target = i_counter[LOW_W-1:0] + i_compare[2*LOW_W-1:LOW_W];
        end
      end
      default: begin
        next_pin = pin;
      end
    endcase
  end

  // State registers only
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin      <= 1'b0;
      target   <= '0;
      lo_hit_q <= 1'b0;
    end else begin
      pin      <= next_pin;
      target   <= next_target;
      lo_hit_q <= lo_hit;
    end
  end

  assign o_pin_level = pin;

endmodule : ccm_pin_gen

`default_nettype wire

// ---- hdl/ccm_top.sv ----
// Overview of operation
// - Match enable sets flag on counter equal compare
// - Toggle enable inverts output pin per match
// - Toggle plus pulse width selects frequency output
// - Pulse width enable drives modulated output pin
// - Wide select picks 16-bit, else 8-bit
// - Flag interrupt enable masks flag interrupt only
`timescale 1ns/1ns
`default_nettype none
`include "ccm_map.svh"

// One capture/compare module: mode control, match flag, pin and interrupt
module ccm_top (
  input  wire logic              i_core_clk,
  input  wire logic              i_resetn,
  input  wire logic [3:0]        i_addr,     // Register address
  input  wire ccm_pkg::ccm_word_t i_wdata,   // Write data
  input  wire logic              i_wr,       // Write strobe
  input  wire logic              i_rd,       // Read strobe
  output ccm_pkg::ccm_word_t     o_rdata,    // Read data, cycle after the strobe
  input  wire ccm_pkg::ccm_word_t i_counter, // Shared counter, same clock domain
  output logic                   o_module_output_pin,
  output logic                   o_irq       // Level interrupt
);

  // Software visible state
  ccm_pkg::ccm_word_t counter_array_mode_reg; // Mode bits
  ccm_pkg::ccm_word_t next_mode;
  ccm_pkg::ccm_word_t compare;                // Compare register
  ccm_pkg::ccm_word_t next_compare;
  ccm_pkg::ccm_word_t status;                 // Sticky event bits
  ccm_pkg::ccm_word_t next_status;
  ccm_pkg::ccm_word_t mask;                   // Interrupt mask, same layout
  ccm_pkg::ccm_word_t next_mask;
  ccm_pkg::ccm_word_t rdata;                  // Read data register
  ccm_pkg::ccm_word_t next_rdata;

  // Event detection state
  logic hit_q;         // Counter equalled compare last cycle
  logic period_q;      // Period start seen last cycle
  logic hit;           // Counter equals compare now
  logic hit_edge;      // First cycle of a match
  logic period_hit;    // Counter at a PWM period start
  logic period_edge;   // First cycle of a period start
  logic match_pulse;   // Match that raises the flag
  logic rd_status;     // Software reads the status register
  ccm_pkg::ccm_word_t set_vec; // Events setting status bits this cycle

  // Decoded mode bits and the match flag from status
  logic match_enable;
  logic toggle_enable;
  logic pulse_width_enable;
  logic wide_pulse_width_select;
  logic module_flag_irq_enable;
  logic module_match_flag;
  ccm_pkg::ccm_mode_e pin_mode; // Selected pin mode

  assign match_enable            = counter_array_mode_reg[`CCM_BIT_MAT_EN];
  assign toggle_enable           = counter_array_mode_reg[`CCM_BIT_TOG_EN];
  assign pulse_width_enable      = counter_array_mode_reg[`CCM_BIT_PWM_EN];
  assign wide_pulse_width_select = counter_array_mode_reg[`CCM_BIT_WIDE];
  assign module_flag_irq_enable  = counter_array_mode_reg[`CCM_BIT_IRQ_EN];
  assign module_match_flag       = status[`CCM_BIT_ST_MATCH];

  // Pin mode decode; both enables together win over either alone
  always_comb begin
    case ({toggle_enable, pulse_width_enable})
      2'b11: begin
        pin_mode = ccm_pkg::ccm_m_freq;
      end
      2'b10: begin
        pin_mode = ccm_pkg::ccm_m_toggle;
      end
      2'b01: begin
        // Width choice is live, so a change takes effect next cycle
        pin_mode = wide_pulse_width_select ? ccm_pkg::ccm_m_pwm16
                                           : ccm_pkg::ccm_m_pwm8;
      end
      default: begin
        pin_mode = ccm_pkg::ccm_m_off;
      end
    endcase
  end

  // Match detection. The counter may dwell on one value for several clocks,
  // so only the first cycle of equality counts as a match.
  assign hit         = (i_counter == compare);
  assign hit_edge    = hit && !hit_q;
  assign match_pulse = hit_edge && match_enable;

  // Period start of the active PWM width, for the period status bit
  always_comb begin
    case (pin_mode)
      ccm_pkg::ccm_m_pwm8: begin
        period_hit = (i_counter[7:0] == 8'h00);
      end
      ccm_pkg::ccm_m_pwm16: begin
        period_hit = (i_counter == 16'h0000);
      end
      default: begin
        period_hit = 1'b0;
      end
    endcase
  end
  assign period_edge = period_hit && !period_q;

  // Events that set sticky status bits
  // The period bit is sticky as well, so a start seen while masked is kept
  always_comb begin
    set_vec                     = '0;
    set_vec[`CCM_BIT_ST_MATCH]  = match_pulse;
    set_vec[`CCM_BIT_ST_PERIOD] = period_edge;
  end

  assign rd_status = i_rd && (i_addr == `CCM_OFS_STATUS);

  // Next register values from the register port and events
  always_comb begin
    next_mode    = counter_array_mode_reg;
    next_compare = compare;
    next_mask    = mask;
    // Read clears the status, but a new event in the same cycle survives
    next_status  = (rd_status ? '0 : status) | set_vec;
    if (i_wr) begin
      case (i_addr)
        `CCM_OFS_MODE: begin
          next_mode = i_wdata;
        end
        `CCM_OFS_CMP: begin
          next_compare = i_wdata;
        end
        `CCM_OFS_MASK: begin
          next_mask = i_wdata;
        end
        default: begin
          // Status and counter are read only; other addresses ignore writes
          next_mode = counter_array_mode_reg;
        end
      endcase
    end
  end

  // Read data; zero in every cycle that follows no read
  always_comb begin
    next_rdata = `CCM_RST_RDATA;
    if (i_rd) begin
      case (i_addr)
        `CCM_OFS_MODE: begin
          next_rdata = counter_array_mode_reg;
        end
        `CCM_OFS_CMP: begin
          next_rdata = compare;
        end
        `CCM_OFS_STATUS: begin
          next_rdata = status;
        end
        `CCM_OFS_MASK: begin
          next_rdata = mask;
        end
        `CCM_OFS_COUNT: begin
          next_rdata = i_counter;
        end
        default: begin
          // Unmapped addresses read as zero
          next_rdata = `CCM_RST_RDATA;
        end
      endcase
    end
  end

  // Register stage for all software visible and event state
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      counter_array_mode_reg <= `CCM_RST_MODE;
      compare                <= `CCM_RST_CMP;
      status                 <= `CCM_RST_STATUS;
      mask                   <= `CCM_RST_MASK;
      rdata                  <= `CCM_RST_RDATA;
      hit_q                  <= 1'b0;
      period_q               <= 1'b0;
    end else begin
      counter_array_mode_reg <= next_mode;
      compare                <= next_compare;
      status                 <= next_status;
      mask                   <= next_mask;
      rdata                  <= next_rdata;
      hit_q                  <= hit;
      period_q               <= period_hit;
    end
  end

  assign o_rdata = rdata;

  // Interrupt: the flag needs both its enable bit and its mask bit.
  // The enable gates only the request, so the flag itself stays visible.
  // The period bit has no enable of its own; its mask bit alone gates it.
  assign o_irq = (module_match_flag && module_flag_irq_enable
                  && mask[`CCM_BIT_ST_MATCH])
              || (status[`CCM_BIT_ST_PERIOD] && mask[`CCM_BIT_ST_PERIOD]);

  // Output pin waveform generator
  ccm_pin_gen #(
    .LOW_W (8)
  ) u_pin_gen (
    .i_core_clk   (i_core_clk),
    .i_resetn     (i_resetn),
    .i_mode       (pin_mode),
    .i_counter    (i_counter),
    .i_compare    (compare),
    .i_match_edge (hit_edge),
    .o_pin_level  (o_module_output_pin)
  );

  // Checks on the block's own behaviour
  // Reset disables every check while it is low, but $past still looks back across a reset release
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (!i_resetn);

  // A fresh match with the function on
  sequence s_armed_match;
    match_enable && hit && !hit_q;
  endsequence

  // Flag set and not being read away
  sequence s_flag_held;
    module_match_flag && !rd_status;
  endsequence

  chk_match_sets_flag: assert property (
    s_armed_match |=> module_match_flag
  ) else $error("match did not set the module flag");

  chk_flag_needs_match: assert property (
    $rose(module_match_flag) |-> $past(match_enable) && $past(hit) && !$past(hit_q)
  ) else $error("module flag rose without an enabled match");

  chk_toggle_flips_pin: assert property (
    (pin_mode == ccm_pkg::ccm_m_toggle) && hit_edge
      |=> o_module_output_pin != $past(o_module_output_pin)
  ) else $error("toggle mode match did not invert the pin");

  chk_toggle_holds_pin: assert property (
    (pin_mode == ccm_pkg::ccm_m_toggle) && !hit_edge |=> $stable(o_module_output_pin)
  ) else $error("toggle mode pin moved without a match");

  chk_freq_mode_sel: assert property (
    toggle_enable && pulse_width_enable |-> pin_mode == ccm_pkg::ccm_m_freq
  ) else $error("both enables did not select frequency output");

  chk_pwm_off_holds: assert property (
    !toggle_enable && !pulse_width_enable |=> $stable(o_module_output_pin)
  ) else $error("pin moved with pulse width and toggle off");

  chk_pwm8_level: assert property (
    pulse_width_enable && !toggle_enable && !wide_pulse_width_select
      |=> o_module_output_pin == ($past(i_counter[7:0]) >= $past(compare[7:0]))
  ) else $error("8-bit pulse width level wrong");

  chk_pwm16_level: assert property (
    pulse_width_enable && !toggle_enable && wide_pulse_width_select
      |=> o_module_output_pin == ($past(i_counter) >= $past(compare))
  ) else $error("16-bit pulse width level wrong");

  chk_irq_masked: assert property (
    !module_flag_irq_enable && !status[`CCM_BIT_ST_PERIOD] |-> !o_irq
  ) else $error("interrupt raised while the flag is masked");

  chk_irq_raised: assert property (
    module_match_flag && module_flag_irq_enable && mask[`CCM_BIT_ST_MATCH] |-> o_irq
  ) else $error("enabled flag did not raise the interrupt");

  chk_flag_sticky: assert property (
    s_flag_held |=> module_match_flag
  ) else $error("module flag dropped without a status read");

  chk_flag_read_clear: assert property (
    rd_status && !match_pulse ##1 !s_armed_match |=> !module_match_flag
  ) else $error("status read did not clear the flag");

  // Frequency mode kept over two edges while the counter rests
  sequence s_freq_steady;
    (pin_mode == ccm_pkg::ccm_m_freq) && ($past(pin_mode) == ccm_pkg::ccm_m_freq)
      && $stable(i_counter);
  endsequence

  // Fresh match seen with the flag interrupt enable off
  sequence s_masked_match;
    match_enable && hit && !hit_q && !module_flag_irq_enable;
  endsequence

  chk_freq_pin_rests: assert property (
    s_freq_steady |=> $stable(o_module_output_pin)
  ) else $error("frequency output moved while the counter rested");

  chk_match_off_quiet: assert property (
    !match_enable && !rd_status |=> module_match_flag == $past(module_match_flag)
  ) else $error("module flag changed with the match function off");

  chk_mask_keeps_flag: assert property (
    s_masked_match ##1 (!module_flag_irq_enable && !status[`CCM_BIT_ST_PERIOD])
      |-> module_match_flag && !o_irq
  ) else $error("masked match lost the flag or raised the interrupt");

  chk_period_sets: assert property (
    period_edge |=> status[`CCM_BIT_ST_PERIOD]
  ) else $error("period start did not set its status bit");

endmodule : ccm_top

`default_nettype wire

// ---- test/ccm_pin_watch.sv ----
`timescale 1ns/1ns
`default_nettype none

// Load on the module output pin: counts every level change it sees
module ccm_pin_watch (
  input  wire logic       i_core_clk,
  input  wire logic       i_resetn,
  input  wire logic       i_pin,     // Pin level from the block
  output logic      [7:0] o_edges    // Level changes seen since reset
);
  logic pin_q;  // Last pin level, one cycle late

  // Edge counter; lags the pin by a cycle, so readers wait two edges
  always_ff @(posedge i_core_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_q   <= 1'b0;
      o_edges <= 8'h00;
    end else begin
      pin_q <= i_pin;
      if (pin_q != i_pin) o_edges <= o_edges + 8'h01;
    end
  end
endmodule : ccm_pin_watch

`default_nettype wire

// ---- test/test_counter_array_module_output_control.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "ccm_map.svh"

// Self-checking bench for one capture/compare module
module test_counter_array_module_output_control;
  logic               i_core_clk;           // Core clock
  logic               i_resetn;             // Reset, active low
  logic [3:0]         i_addr;               // Register address
  ccm_pkg::ccm_word_t i_wdata;              // Write data
  logic               i_wr;                 // Write strobe
  logic               i_rd;                 // Read strobe
  ccm_pkg::ccm_word_t o_rdata;              // Read data
  ccm_pkg::ccm_word_t i_counter;            // Shared counter
  logic               o_module_output_pin;  // Pin level
  logic               o_irq;                // Interrupt level
  logic [7:0]         edges;                // Pin edges seen by the load
  logic [7:0]         e0;                   // Edge count at start of a test
  logic               exp_pin;              // Expected pin level
  logic               rd_d = 1'b0;          // Read taken at the last edge
  ccm_pkg::ccm_word_t exp_q[$];             // Expected read data, oldest first
  int                 errors;
  int                 checks_done;
  logic [31:0]        rng;                  // Xorshift state

  ccm_top u_ccm_top (.i_core_clk(i_core_clk), .i_resetn(i_resetn), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_counter(i_counter),
    .o_module_output_pin(o_module_output_pin), .o_irq(o_irq));

  ccm_pin_watch u_ccm_pin_watch (.i_core_clk(i_core_clk), .i_resetn(i_resetn),
    .i_pin(o_module_output_pin), .o_edges(edges));

  // Free-running 100 MHz clock
  initial begin
    i_core_clk = 1'b0;
    forever #5 i_core_clk = ~i_core_clk;
  end

  // Compare one value; a 1-bit result is passed zero-extended
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask : chk

  // Xorshift step; the seed is fixed so runs repeat
  function automatic logic [31:0] xs(input logic [31:0] x);
    x = x ^ (x << 13);
    x = x ^ (x >> 17);
    return x ^ (x << 5);
  endfunction : xs

  // One-cycle write strobe
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge i_core_clk);
    i_wr    <= 1'b1;
    i_addr  <= a;
    i_wdata <= d;
    @(posedge i_core_clk);
    i_wr <= 1'b0;
  endtask : wr

  // One-cycle read strobe; the expected word waits in the queue
  task automatic rd(input logic [3:0] a, input logic [15:0] e);
    @(posedge i_core_clk);
    i_rd   <= 1'b1;
    i_addr <= a;
    exp_q.push_back(e);
    @(posedge i_core_clk);
    i_rd <= 1'b0;
  endtask : rd

  // Present a counter value, let n more edges pass, stop mid-cycle
  task automatic cnt(input logic [15:0] v, input int n);
    @(posedge i_core_clk);
    i_counter <= v;
    repeat (n) @(posedge i_core_clk);
    @(negedge i_core_clk);
  endtask : cnt

  // Verdict and end of run
  task automatic complete_run;
    if (exp_q.size() != 0) begin
      errors++;
      $display("FAIL read queue expected empty seen %0d left", exp_q.size());
    end
    $display("checks %0d mismatches %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : complete_run

  // Read data stand only in the cycle after the strobe, so look there
  always @(posedge i_core_clk) rd_d <= i_rd;
  always @(negedge i_core_clk) begin
    if (rd_d && exp_q.size() == 0) begin
      errors++;
      $display("FAIL read data expected none seen %h", o_rdata);
    end else if (rd_d) begin
      chk("read data", exp_q.pop_front(), o_rdata);
    end
  end

  // Cut a hang short
  initial begin
    repeat (20000) @(posedge i_core_clk);
    errors++;
    $display("FAIL watchdog expected end seen hang");
    complete_run();
  end

  // Main sequence
  initial begin
    errors = 0;
    checks_done = 0;
    rng = 32'h0000003B;
    i_resetn = 1'b0;
    i_addr = 4'h0;
    i_wdata = 16'h0000;
    i_wr = 1'b0;
    i_rd = 1'b0;
    i_counter = 16'h0000;
    repeat (2) @(posedge i_core_clk);
    i_resetn <= 1'b1;
    // Reset values, status not writable, unmapped read gives zero
    chk("pin", 16'h0000, {15'h0, o_module_output_pin});
    chk("irq", 16'h0000, {15'h0, o_irq});
    rd(`CCM_OFS_MODE, `CCM_RST_MODE);
    rd(`CCM_OFS_CMP, `CCM_RST_CMP);
    rd(`CCM_OFS_MASK, `CCM_RST_MASK);
    wr(`CCM_OFS_STATUS, 16'hFFFF);
    rd(`CCM_OFS_STATUS, `CCM_RST_STATUS);
    rd(4'hF, 16'h0000);
    $display("test reset done");
    // Match with toggle; flag held while the interrupt is masked
    wr(`CCM_OFS_CMP, 16'h0010);
    wr(`CCM_OFS_MODE, 16'h000C);
    cnt(16'h0010, 1);
    chk("toggle pin", 16'h0001, {15'h0, o_module_output_pin});
    cnt(16'h0010, 3);
    chk("dwell pin", 16'h0001, {15'h0, o_module_output_pin});
    chk("masked irq", 16'h0000, {15'h0, o_irq});
    wr(`CCM_OFS_MODE, 16'h000D);
    @(negedge i_core_clk);
    chk("held flag irq", 16'h0001, {15'h0, o_irq});
    wr(`CCM_OFS_MASK, 16'h0000);
    @(negedge i_core_clk);
    chk("mask off irq", 16'h0000, {15'h0, o_irq});
    wr(`CCM_OFS_MASK, `CCM_RST_MASK);
    rd(`CCM_OFS_COUNT, 16'h0010);
    rd(`CCM_OFS_STATUS, 16'h0001);
    rd(`CCM_OFS_STATUS, 16'h0000);
    @(negedge i_core_clk);
    chk("cleared irq", 16'h0000, {15'h0, o_irq});
    // Match disabled: pin still toggles, flag stays clear
    wr(`CCM_OFS_MODE, 16'h0005);
    cnt(16'h0000, 1);
    cnt(16'h0010, 1);
    chk("toggle back pin", 16'h0000, {15'h0, o_module_output_pin});
    rd(`CCM_OFS_STATUS, 16'h0000);
    @(negedge i_core_clk);
    chk("no flag irq", 16'h0000, {15'h0, o_irq});
    wr(`CCM_OFS_MODE, 16'h0000);
    cnt(16'h0000, 1);
    cnt(16'h0010, 1);
    chk("toggle off pin", 16'h0000, {15'h0, o_module_output_pin});
    $display("test match done");
    // Narrow then wide modulation against random counter values
    for (int m = 0; m < 2; m++) begin
      wr(`CCM_OFS_CMP, (m != 0) ? 16'h8000 : 16'h1280);
      wr(`CCM_OFS_MODE, (m != 0) ? 16'h0082 : 16'h0002);
      for (int i = 0; i < 24; i++) begin
        rng = xs(rng);
        cnt(rng[15:0], 1);
        exp_pin = (m != 0) ? (rng[15:0] >= 16'h8000) : (rng[7:0] >= 8'h80);
        chk("pwm pin", {15'h0, exp_pin}, {15'h0, o_module_output_pin});
      end
    end
    // A period start of the wide form sets its sticky bit and the interrupt
    cnt(16'h0001, 1);
    cnt(16'h0000, 1);
    chk("period irq", 16'h0001, {15'h0, o_irq});
    rd(`CCM_OFS_STATUS, 16'h0002);
    @(negedge i_core_clk);
    chk("period irq cleared", 16'h0000, {15'h0, o_irq});
    // Modulation off: pin holds whatever the counter does
    wr(`CCM_OFS_MODE, 16'h0000);
    @(negedge i_core_clk);
    exp_pin = o_module_output_pin;
    for (int i = 0; i < 8; i++) begin
      rng = xs(rng);
      cnt(rng[15:0], 1);
      chk("off pin", {15'h0, exp_pin}, {15'h0, o_module_output_pin});
    end
    $display("test pwm done");
    // Frequency output: step 4 from target 5 gives edges at 5, 9, 13, 17
    cnt(16'h0000, 1);
    wr(`CCM_OFS_CMP, 16'h0405);
    wr(`CCM_OFS_MODE, 16'h0006);
    e0 = edges;
    for (int i = 1; i <= 20; i++) cnt(16'(i), 0);
    cnt(16'h0014, 2);
    chk("freq edges", 16'h0004, 16'(edges - e0));
    $display("test freq done");
    repeat (2) @(posedge i_core_clk);
    complete_run();
  end
endmodule : test_counter_array_module_output_control

`default_nettype wire
